// ==== verilog/power_pkg.sv ====
package power_pkg;
  // register map
  localparam logic [7:0] SLEEP_POWER_CONTROL_ADDR = 8'h8F;
  localparam logic [7:0] STATUS_ADDR = 8'h90;
  localparam logic [7:0] SLEEP_POWER_CONTROL_RESET = 8'h3F;
  localparam logic [7:0] SLEEP_POWER_CONTROL_MASK = 8'hBF;
  // field positions of sleep_power_control
  localparam int HIBERNATE_SELECT_BIT = 7;
  localparam int REFERENCES_OFF_BIT = 5;
  localparam int LEVEL_SHIFT_OFF_BIT = 4;
  localparam int OSC_SLEEP_OFF_BIT = 3;
  localparam int COMPARATOR_OFF_BIT = 2;
  localparam int TEMP_SENSOR_OFF_BIT = 1;
  localparam int CONVERTER_OFF_BIT = 0;
  // field positions of the status word
  localparam int TIMEOUT_FLAG_BIT = 0;
  localparam int POWER_DOWN_FLAG_BIT = 1;
  localparam int STATE_LSB = 2;
  // number of wake-up interrupt sources
  localparam int IRQ_SOURCES = 6;
  // enable bit positions of the pin interrupt sources
  localparam int PUSH_BUTTON_IRQ = 0;
  localparam int PORT_CHANGE_IRQ = 1;
  // oscillator restart settle time
  localparam int OSC_SETTLE_NS = 1000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] OSC_SETTLE_COUNT = 8'(OSC_SETTLE_CYCLES);
  localparam logic [7:0] OSC_COUNT_ZERO = 8'h00;
  localparam logic [7:0] OSC_COUNT_ONE = 8'h01;

  typedef enum logic [1:0] {
    RUN,
    SLEEP,
    HIBERNATE,
    WAKING
  } power_state_type;
endpackage : power_pkg

// ==== verilog/wake_sync_if.sv ====
`timescale 1ns/1ps
// synchronised wake-up inputs handed from the pin stage to the sequencer
interface wake_sync_if;
  logic masterClearLevel;
  logic pushButtonFall;
  logic portChangeEvent;
  modport source (output masterClearLevel, output pushButtonFall, output portChangeEvent);
  modport sink (input masterClearLevel, input pushButtonFall, input portChangeEvent);
endinterface : wake_sync_if

// ==== verilog/pin_synchroniser.sv ====
`timescale 1ns/1ps
// three-stage pin synchroniser; a change counts when stages two and three agree
module pin_synchroniser #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] stableOut,
  output logic [WIDTH-1:0] changed
);
  logic [WIDTH-1:0] stageOne_q;
  logic [WIDTH-1:0] stageTwo_q;
  logic [WIDTH-1:0] stageThree_q;
  logic [WIDTH-1:0] stable_q;
  wire [WIDTH-1:0] agree = ~(stageTwo_q ^ stageThree_q);
  wire [WIDTH-1:0] stable_d = (agree & stageThree_q) | (~agree & stable_q);

  // shift chain and agreed level
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      stageOne_q <= '0;
      stageTwo_q <= '0;
      stageThree_q <= '0;
      stable_q <= '0;
    end else begin
      stageOne_q <= pinIn;
      stageTwo_q <= stageOne_q;
      stageThree_q <= stageTwo_q;
      stable_q <= stable_d;
    end
  end

  assign stableOut = stable_q;
  assign changed = stable_q ^ stable_d;
endmodule : pin_synchroniser

// ==== verilog/sleep_hibernate_power_manager.sv ====
`timescale 1ns/1ps
// Overview of operation
// - sleep instruction enters sleep, cpu clock stopped
// - sleep entry clears watchdog, power-down flag, sets timeout
// - ports hold their drive state during sleep
// - oscillator runs unless sleeping with off bit
// - listed wake sources end sleep
// - master clear resets; other sources resume
// - watchdog wake clears the timeout flag
// - wake needs source enable, ignores global enable
// - resume next instruction, vector if global enabled and an enabled flag is pending
// - next instruction prefetched during sleep instruction
// - watchdog cleared on every wake-up except master clear
// - pending enabled flag wakes at once
// - hibernate select turns sleep into hibernate
// - hibernate stops watchdog, pull-ups, some buffers
// - watchdog timeout never wakes hibernate
// - control resets to 3F, bit six reads zero
// - references off bit powers down references
// - level shift off bit disables level shifters
// - comparator off bit powers down comparators
// - temp sensor off bit powers down sensor
// - converter off bit powers down converter parts
// - current source needs converter on and setting
// - watchdog timeout in sleep wakes, no reset
module sleep_hibernate_power_manager (
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  // cpu core side
  input wire logic sleepInstruction,
  input wire logic globalIrqEnable,
  input wire logic [5:0] irqEnable,
  input wire logic [5:0] irqFlag,
  input wire logic [3:0] converterCurrentSetting,
  output logic cpuClockEnable,
  output logic prefetchNext,
  output logic resumeExecution,
  output logic branchToVector,
  output logic deviceReset,
  output logic powerDownFlag,
  output logic timeoutFlag,
  output logic ioHold,
  // pins
  input wire logic masterClearPinN,
  input wire logic pushButtonPin,
  input wire logic [3:0] portChangePins,
  // watchdog
  input wire logic watchdogConfigEnable,
  input wire logic watchdogTimeout,
  output logic watchdogClear,
  output logic watchdogRun,
  // analog power switches and oscillator
  output logic mainOscEnable,
  output logic pullUpDisable,
  output logic inputBufferGate,
  output logic referencesPowerOff,
  output logic levelShiftPowerOff,
  output logic comparatorPowerOff,
  output logic tempSensorPowerOff,
  output logic converterPowerOff,
  output logic currentSourceEnable
);
  power_pkg::power_state_type state_q, state_d;
  logic [7:0] sleepPowerControl_q;
  logic powerDownFlag_q;
  logic timeoutFlag_q;
  logic [7:0] oscCount_q;
  logic [7:0] readData_q;
  logic cpuClockEnable_q;
  logic prefetchNext_q;
  logic resumeExecution_q;
  logic branchToVector_q;
  logic deviceReset_q;
  logic ioHold_q;
  logic watchdogClear_q;
  logic watchdogRun_q;
  logic mainOscEnable_q;
  logic pullUpDisable_q;
  logic inputBufferGate_q;
  logic currentSourceEnable_q;
  logic pushButtonLevel;
  logic [3:0] portLevel;
  logic [3:0] portChanged;
  logic pushButtonChanged;
  logic masterClearChanged;
  wake_sync_if wakeSync ();

  // pin synchronisation; high-idle pins inverted so reset level equals idle
  pin_synchroniser #(.WIDTH(6)) pinSync (
    .mclk(mclk),
    .reset(reset),
    .pinIn({~masterClearPinN, ~pushButtonPin, portChangePins}),
    .stableOut({wakeSync.masterClearLevel, pushButtonLevel, portLevel}),
    .changed({masterClearChanged, pushButtonChanged, portChanged})
  );
  assign wakeSync.pushButtonFall = pushButtonChanged & ~pushButtonLevel; // inverted rise
  assign wakeSync.portChangeEvent = |portChanged;

  // register decode
  wire writeControl = regWrite && (regAddr == power_pkg::SLEEP_POWER_CONTROL_ADDR);
  wire readControl = regAddr == power_pkg::SLEEP_POWER_CONTROL_ADDR;
  wire readStatus = regAddr == power_pkg::STATUS_ADDR;
  wire [7:0] controlView = sleepPowerControl_q & power_pkg::SLEEP_POWER_CONTROL_MASK;
  wire [7:0] statusView = {4'h0, 2'(state_q), powerDownFlag_q, timeoutFlag_q};
  wire [7:0] readData_d = !regRead ? 8'h00 : readControl ? controlView :
                          readStatus ? statusView : 8'h00;

  // field decode
  wire hibernateSelect = sleepPowerControl_q[power_pkg::HIBERNATE_SELECT_BIT];
  wire mainOscSleepOff = sleepPowerControl_q[power_pkg::OSC_SLEEP_OFF_BIT];
  wire asleep = (state_q == power_pkg::SLEEP) || (state_q == power_pkg::HIBERNATE);

  // wake-up source sorting
  wire masterClearActive = wakeSync.masterClearLevel; // already inverted
  wire [5:0] enabledPending = irqEnable & irqFlag;
  wire irqWake = |enabledPending;
  wire watchdogWake = watchdogTimeout && watchdogConfigEnable
                      && (state_q == power_pkg::SLEEP);
  wire pushButtonWake = wakeSync.pushButtonFall && irqEnable[power_pkg::PUSH_BUTTON_IRQ];
  wire portChangeWake = wakeSync.portChangeEvent && irqEnable[power_pkg::PORT_CHANGE_IRQ];
  wire pinWake = pushButtonWake || portChangeWake;
  wire softWake = asleep && (irqWake || watchdogWake || pinWake);
  wire resetWake = masterClearActive;
  wire oscWasStopped = !mainOscEnable_q;

  // power state sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      power_pkg::RUN: begin
        if (sleepInstruction) begin
          state_d = hibernateSelect ? power_pkg::HIBERNATE : power_pkg::SLEEP;
        end
      end
      power_pkg::SLEEP, power_pkg::HIBERNATE: begin
        if (softWake) begin
          state_d = power_pkg::WAKING;
        end
      end
      power_pkg::WAKING: begin
        if (oscCount_q <= power_pkg::OSC_COUNT_ONE) begin
          state_d = power_pkg::RUN;
        end
      end
    endcase
  end

  // state and oscillator settle counter
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= power_pkg::RUN;
      oscCount_q <= power_pkg::OSC_COUNT_ZERO;
    end else if (resetWake) begin
      state_q <= power_pkg::RUN;
      oscCount_q <= power_pkg::OSC_COUNT_ZERO;
    end else begin
      state_q <= state_d;
      if (softWake) begin
        oscCount_q <= oscWasStopped ? power_pkg::OSC_SETTLE_COUNT : power_pkg::OSC_COUNT_ONE;
      end else if (oscCount_q != power_pkg::OSC_COUNT_ZERO) begin
        oscCount_q <= oscCount_q - power_pkg::OSC_COUNT_ONE;
      end
    end
  end

  // control register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sleepPowerControl_q <= power_pkg::SLEEP_POWER_CONTROL_RESET;
    end else if (writeControl) begin
      sleepPowerControl_q <= regWriteData & power_pkg::SLEEP_POWER_CONTROL_MASK;
    end
  end

  // status flags: power-down set on power-up, both set by reset
  wire entering = (state_q == power_pkg::RUN) && sleepInstruction;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      powerDownFlag_q <= 1'b1;
      timeoutFlag_q <= 1'b1;
    end else if (entering) begin
      powerDownFlag_q <= 1'b0;
      timeoutFlag_q <= 1'b1;
    end else if (asleep && watchdogWake) begin
      timeoutFlag_q <= 1'b0;
    end
  end

  // cpu-side next values
  wire wakeDone = (state_q == power_pkg::WAKING) && (state_d == power_pkg::RUN);
  wire cpuClockEnable_d = (state_d == power_pkg::RUN) || resetWake;
  wire prefetchNext_d = entering;
  wire resumeExecution_d = wakeDone && !resetWake;
  wire branchToVector_d = resumeExecution_d && globalIrqEnable && irqWake;
  // full reset request stands while master clear is held after sleep
  wire resetAfterSleep = asleep || (state_q == power_pkg::WAKING) || deviceReset_q;
  wire deviceReset_d = resetWake && resetAfterSleep;
  wire ioHold_d = (state_d != power_pkg::RUN) && !resetWake;

  // cpu clock gate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cpuClockEnable_q <= 1'b1;
    end else begin
      cpuClockEnable_q <= cpuClockEnable_d;
    end
  end

  // prefetch pulse on sleep entry
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prefetchNext_q <= 1'b0;
    end else begin
      prefetchNext_q <= prefetchNext_d;
    end
  end

  // resume pulse at wake completion
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      resumeExecution_q <= 1'b0;
    end else begin
      resumeExecution_q <= resumeExecution_d;
    end
  end

  // vector branch beside the resume pulse
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      branchToVector_q <= 1'b0;
    end else begin
      branchToVector_q <= branchToVector_d;
    end
  end

  // full reset request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      deviceReset_q <= 1'b0;
    end else begin
      deviceReset_q <= deviceReset_d;
    end
  end

  // port drive hold
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ioHold_q <= 1'b0;
    end else begin
      ioHold_q <= ioHold_d;
    end
  end

  // watchdog, oscillator and hibernate next values
  wire stopOsc = (state_d == power_pkg::SLEEP || state_d == power_pkg::HIBERNATE)
                 && mainOscSleepOff && !resetWake;
  wire inHibernate = (state_d == power_pkg::HIBERNATE) && !resetWake;
  wire watchdogClear_d = entering || softWake;
  wire watchdogRun_d = watchdogConfigEnable && !inHibernate;
  wire mainOscEnable_d = !stopOsc;

  // watchdog clear pulse
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      watchdogClear_q <= 1'b0;
    end else begin
      watchdogClear_q <= watchdogClear_d;
    end
  end

  // watchdog run, forced off in hibernate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      watchdogRun_q <= 1'b0;
    end else begin
      watchdogRun_q <= watchdogRun_d;
    end
  end

  // main oscillator enable
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mainOscEnable_q <= 1'b1;
    end else begin
      mainOscEnable_q <= mainOscEnable_d;
    end
  end

  // weak pull-up disable in hibernate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pullUpDisable_q <= 1'b0;
    end else begin
      pullUpDisable_q <= inHibernate;
    end
  end

  // input buffer gating in hibernate
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      inputBufferGate_q <= 1'b0;
    end else begin
      inputBufferGate_q <= inHibernate;
    end
  end

  // current source enable and read data
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      currentSourceEnable_q <= 1'b0;
      readData_q <= 8'h00;
    end else begin
      currentSourceEnable_q <= !sleepPowerControl_q[power_pkg::CONVERTER_OFF_BIT]
                               && (|converterCurrentSetting);
      readData_q <= readData_d;
    end
  end

  // output assignments
  assign regReadData = readData_q;
  assign cpuClockEnable = cpuClockEnable_q;
  assign prefetchNext = prefetchNext_q;
  assign resumeExecution = resumeExecution_q;
  assign branchToVector = branchToVector_q;
  assign deviceReset = deviceReset_q;
  assign powerDownFlag = powerDownFlag_q;
  assign timeoutFlag = timeoutFlag_q;
  assign ioHold = ioHold_q;
  assign watchdogClear = watchdogClear_q;
  assign watchdogRun = watchdogRun_q;
  assign mainOscEnable = mainOscEnable_q;
  assign pullUpDisable = pullUpDisable_q;
  assign inputBufferGate = inputBufferGate_q;
  // analog power switches straight from register bits, current source from its flop
  assign referencesPowerOff = sleepPowerControl_q[power_pkg::REFERENCES_OFF_BIT];
  assign levelShiftPowerOff = sleepPowerControl_q[power_pkg::LEVEL_SHIFT_OFF_BIT];
  assign comparatorPowerOff = sleepPowerControl_q[power_pkg::COMPARATOR_OFF_BIT];
  assign tempSensorPowerOff = sleepPowerControl_q[power_pkg::TEMP_SENSOR_OFF_BIT];
  assign converterPowerOff = sleepPowerControl_q[power_pkg::CONVERTER_OFF_BIT];
  assign currentSourceEnable = currentSourceEnable_q;
endmodule : sleep_hibernate_power_manager

// ==== test/irq_source_model.sv ====
`timescale 1ns/1ps
// peripheral interrupt flags beside the cpu core
module irq_source_model (
  input logic mclk,
  input logic reset,
  input logic [5:0] raise,
  input logic [5:0] clear,
  output logic [5:0] irqFlag
);
  logic [5:0] flags_q;
  // flags latch every event whatever the enables; only software or reset clears them
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_q <= 6'h00;
    end else begin
      flags_q <= (flags_q | raise) & ~clear;
    end
  end
  assign irqFlag = flags_q;
endmodule : irq_source_model

// ==== test/sleep_hibernate_power_manager_chk.sv ====
`timescale 1ns/1ps
// port watcher for the power manager
module power_sleep_chk (
  input logic mclk,
  input logic reset,
  input logic regRead,
  input logic [7:0] regReadData,
  input logic sleepInstruction,
  input logic globalIrqEnable,
  input logic [5:0] irqEnable,
  input logic [5:0] irqFlag,
  input logic [3:0] converterCurrentSetting,
  input logic cpuClockEnable,
  input logic prefetchNext,
  input logic resumeExecution,
  input logic branchToVector,
  input logic powerDownFlag,
  input logic timeoutFlag,
  input logic ioHold,
  input logic watchdogClear,
  input logic watchdogRun,
  input logic mainOscEnable,
  input logic pullUpDisable,
  input logic inputBufferGate,
  input logic converterPowerOff,
  input logic currentSourceEnable
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  // sleep entry and its side effects
  a_sleep_entry: assert property (
    sleepInstruction && cpuClockEnable && !ioHold |=> !cpuClockEnable && prefetchNext
      && watchdogClear && !powerDownFlag && timeoutFlag && ioHold) else $error("bad entry");
  a_osc_first: assert property (
    cpuClockEnable |-> mainOscEnable) else $error("cpu clock without osc");
  a_hib_wdog: assert property (
    pullUpDisable |-> !watchdogRun && inputBufferGate) else $error("hibernate extras");
  a_no_hibwake: assert property (
    $fell(timeoutFlag) |-> !$past(pullUpDisable)) else $error("watchdog woke hibernate");
  a_vector_gie: assert property (
    branchToVector |-> resumeExecution && $past(globalIrqEnable)) else $error("bad vector");
  a_src_off: assert property (
    converterPowerOff [*2] |-> !currentSourceEnable) else $error("source on while off");
  a_src_on: assert property (
    (!converterPowerOff && converterCurrentSetting != 4'h0) [*2] |-> currentSourceEnable)
    else $error("source not on");
  a_bit_six: assert property (
    $past(regRead) |-> !regReadData[6]) else $error("bit six set");
  a_read_idle: assert property (
    !$past(regRead) |-> regReadData == 8'h00) else $error("stray read data");
  a_pending_wake: assert property (
    ioHold && !cpuClockEnable && (irqEnable & irqFlag) != 6'h00 |-> ##[1:14] resumeExecution)
    else $error("no wake");
  // main scenarios
  c_entry: cover property (prefetchNext);
  c_vector: cover property (branchToVector);
  c_hibernate: cover property (pullUpDisable && ioHold);
endmodule : power_sleep_chk

bind sleep_hibernate_power_manager power_sleep_chk chk (
  .mclk(mclk), .reset(reset), .regRead(regRead), .regReadData(regReadData),
  .sleepInstruction(sleepInstruction), .globalIrqEnable(globalIrqEnable),
  .irqEnable(irqEnable), .irqFlag(irqFlag),
  .converterCurrentSetting(converterCurrentSetting), .cpuClockEnable(cpuClockEnable),
  .prefetchNext(prefetchNext), .resumeExecution(resumeExecution),
  .branchToVector(branchToVector), .powerDownFlag(powerDownFlag),
  .timeoutFlag(timeoutFlag), .ioHold(ioHold), .watchdogClear(watchdogClear),
  .watchdogRun(watchdogRun), .mainOscEnable(mainOscEnable),
  .pullUpDisable(pullUpDisable), .inputBufferGate(inputBufferGate),
  .converterPowerOff(converterPowerOff), .currentSourceEnable(currentSourceEnable)
);

// ==== test/sleep_hibernate_power_manager_bench.sv ====
`timescale 1ns/1ps
// directed bench for the sleep and hibernate power manager
module sleep_hibernate_power_manager_bench;
  localparam logic [7:0] CTRL = power_pkg::SLEEP_POWER_CONTROL_ADDR;
  localparam logic [7:0] STAT = power_pkg::STATUS_ADDR;
  logic mclk, reset, regWrite, regRead, sleepInstruction, globalIrqEnable;
  logic [7:0] regAddr, regWriteData, regReadData;
  logic [5:0] irqEnable, irqFlag, raise, clear;
  logic [3:0] converterCurrentSetting, portChangePins;
  logic cpuClockEnable, prefetchNext, resumeExecution, branchToVector, deviceReset;
  logic powerDownFlag, timeoutFlag, ioHold, masterClearPinN, pushButtonPin;
  logic watchdogConfigEnable, watchdogTimeout, watchdogClear, watchdogRun, mainOscEnable;
  logic pullUpDisable, inputBufferGate, referencesPowerOff, levelShiftPowerOff;
  logic comparatorPowerOff, tempSensorPowerOff, converterPowerOff, currentSourceEnable;
  int failCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  sleep_hibernate_power_manager dut (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .sleepInstruction(sleepInstruction), .globalIrqEnable(globalIrqEnable),
    .irqEnable(irqEnable), .irqFlag(irqFlag),
    .converterCurrentSetting(converterCurrentSetting),
    .cpuClockEnable(cpuClockEnable), .prefetchNext(prefetchNext),
    .resumeExecution(resumeExecution), .branchToVector(branchToVector),
    .deviceReset(deviceReset), .powerDownFlag(powerDownFlag), .timeoutFlag(timeoutFlag),
    .ioHold(ioHold), .masterClearPinN(masterClearPinN), .pushButtonPin(pushButtonPin),
    .portChangePins(portChangePins), .watchdogConfigEnable(watchdogConfigEnable),
    .watchdogTimeout(watchdogTimeout), .watchdogClear(watchdogClear),
    .watchdogRun(watchdogRun), .mainOscEnable(mainOscEnable),
    .pullUpDisable(pullUpDisable), .inputBufferGate(inputBufferGate),
    .referencesPowerOff(referencesPowerOff), .levelShiftPowerOff(levelShiftPowerOff),
    .comparatorPowerOff(comparatorPowerOff), .tempSensorPowerOff(tempSensorPowerOff),
    .converterPowerOff(converterPowerOff), .currentSourceEnable(currentSourceEnable)
  );
  irq_source_model partner (.mclk(mclk), .reset(reset), .raise(raise), .clear(clear),
    .irqFlag(irqFlag));
  // clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : endOfTest
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      endOfTest();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    chk(regReadData, exp);
  endtask : rd
  task automatic sleepNow();
    repeat (2) @(posedge mclk);
    sleepInstruction <= 1'b1;
    @(posedge mclk);
    sleepInstruction <= 1'b0;
    #1;
  endtask : sleepNow
  task automatic waitWake(input logic expBranch);
    int n;
    logic sawClear;
    n = 0;
    sawClear = watchdogClear;
    while (resumeExecution !== 1'b1 && n < 40) begin
      tick(1);
      n++;
      sawClear = sawClear | watchdogClear;
    end
    chk(resumeExecution, 1'b1);
    chk(branchToVector, expBranch);
    chk(sawClear, 1'b1);
  endtask : waitWake
  task automatic flagOp(input logic [5:0] s, input logic [5:0] c);
    @(posedge mclk);
    raise <= s;
    clear <= c;
    @(posedge mclk);
    raise <= 6'h00;
    clear <= 6'h00;
  endtask : flagOp
  // main sequence
  initial begin
    reset = 1'b1;
    {regWrite, regRead, sleepInstruction, globalIrqEnable, watchdogTimeout} = 5'h00;
    {regAddr, regWriteData, irqEnable, raise, clear} = 34'h0;
    {converterCurrentSetting, portChangePins} = 8'h00;
    {masterClearPinN, pushButtonPin, watchdogConfigEnable} = 3'h7;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    rd(CTRL, power_pkg::SLEEP_POWER_CONTROL_RESET);
    chk({referencesPowerOff, levelShiftPowerOff, comparatorPowerOff, tempSensorPowerOff,
      converterPowerOff}, 8'h1F);
    for (int k = 0; k < 5; k++) begin
      wr(CTRL, 8'h20 >> k + (k > 1));
      chk({referencesPowerOff, levelShiftPowerOff, comparatorPowerOff, tempSensorPowerOff,
        converterPowerOff}, 8'h10 >> k);
    end
    wr(CTRL, 8'hFF);
    wr(8'h55, 8'h00);
    rd(CTRL, 8'hBF);
    rd(8'h55, 8'h00);
    wr(CTRL, 8'h00);
    converterCurrentSetting <= 4'h3;
    tick(3);
    chk(currentSourceEnable, 1'b1);
    wr(CTRL, 8'h01);
    tick(2);
    chk(currentSourceEnable, 1'b0);
    wr(CTRL, 8'h00);
    // sleep with oscillator kept, disabled flag must not wake
    sleepNow();
    chk({cpuClockEnable, prefetchNext, ioHold, mainOscEnable, powerDownFlag, timeoutFlag,
      watchdogClear, watchdogRun}, 8'h77);
    rd(STAT, 8'h05);
    flagOp(6'h04, 6'h00);
    tick(20);
    chk(ioHold, 1'b1);
    irqEnable <= 6'h04;
    waitWake(1'b0);
    flagOp(6'h00, 6'h04);
    irqEnable <= 6'h00;
    // oscillator stopped, port change wakes
    wr(CTRL, 8'h08);
    irqEnable <= 6'h02;
    sleepNow();
    chk(mainOscEnable, 1'b0);
    portChangePins <= 4'h1;
    waitWake(1'b0);
    // pending enabled flag at entry wakes at once and vectors
    globalIrqEnable <= 1'b1;
    irqEnable <= 6'h04;
    flagOp(6'h04, 6'h00);
    sleepNow();
    waitWake(1'b1);
    flagOp(6'h00, 6'h04);
    globalIrqEnable <= 1'b0;
    irqEnable <= 6'h00;
    // watchdog timeout in sleep resumes
    wr(CTRL, 8'h00);
    sleepNow();
    watchdogTimeout <= 1'b1;
    tick(1);
    watchdogTimeout <= 1'b0;
    waitWake(1'b0);
    chk({timeoutFlag, deviceReset}, 8'h00);
    // hibernate ignores the watchdog, push button wakes
    wr(CTRL, 8'h80);
    sleepNow();
    chk({watchdogRun, pullUpDisable, inputBufferGate, ioHold}, 8'h07);
    rd(STAT, 8'h09);
    watchdogTimeout <= 1'b1;
    tick(1);
    watchdogTimeout <= 1'b0;
    tick(20);
    chk(ioHold, 1'b1);
    irqEnable <= 6'h01;
    pushButtonPin <= 1'b0;
    waitWake(1'b0);
    pushButtonPin <= 1'b1;
    // master clear during sleep asks for a full reset
    wr(CTRL, 8'h00);
    sleepNow();
    masterClearPinN <= 1'b0;
    tick(8);
    chk(deviceReset, 1'b1);
    masterClearPinN <= 1'b1;
    tick(8);
    chk({deviceReset, cpuClockEnable, ioHold}, 8'h02);
    endOfTest();
  end
endmodule : sleep_hibernate_power_manager_bench
